// file: design/rvsr_top.sv
// register slice: converter two targets and slew, linear regulator codes with strap presets
`timescale 1ns/100ps

module rvsr_top #(
	parameter int STEP_BASE_CYCLES = rvsr_pkg::RVSR_FAST_STEP_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic strap_select_a,
	input wire logic strap_select_b,
	input wire logic step_down_two_select_pin,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wr_data,
	output logic [7:0] reg_rd_data,
	output logic [2:0] slew_code,
	output logic [3:0][2:0] linear_reg_code,
	output logic [3:0][11:0] linear_reg_mv,
	output logic [5:0] converter_code,
	output rvsr_pkg::rvsr_mv_t converter_mv,
	output logic ramp_busy,
	output logic presets_loaded
);
	import rvsr_pkg::*;

	// pin synchronisers: index 0 strap a, 1 strap b, 2 converter select
	logic [2:0] pin_raw;
	logic [2:0] pin_clean;

	assign pin_raw = {step_down_two_select_pin, strap_select_b, strap_select_a};

	genvar gp;
	generate
		for (gp = 0; gp < 3; gp++) begin : g_sync
			logic s1_reg, s2_reg, s3_reg, clean_reg, clean_next;
			always_comb begin
				clean_next = (s2_reg == s3_reg) ? s3_reg : clean_reg;
			end
			always_ff @(posedge ref_clk) begin
				if (!rstn) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
					s3_reg <= 1'b0;
					clean_reg <= 1'b0;
				end else begin
					s1_reg <= pin_raw[gp];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					clean_reg <= clean_next;
				end
			end
			assign pin_clean[gp] = clean_reg;
		end
	endgenerate

	// register state
	logic [5:0] conv_low_reg, conv_low_next;
	logic [5:0] conv_high_reg, conv_high_next;
	logic [2:0] slew_reg, slew_next;
	logic [3:0][2:0] ldo_reg, ldo_next;
	logic [2:0] settle_reg, settle_next;
	logic loaded_reg, loaded_next;
	logic [7:0] rd_reg, rd_next;
	logic wr_conv_low, wr_conv_high, wr_slew, wr_ldo_a, wr_ldo_b, wr_ldo;
	logic [11:0] strap_preset;

	assign wr_conv_low = reg_wr_en && reg_addr == RVSR_ADDR_CONV_LOW;
	assign wr_conv_high = reg_wr_en && reg_addr == RVSR_ADDR_CONV_HIGH;
	assign wr_slew = reg_wr_en && reg_addr == RVSR_ADDR_SLEW;
	assign wr_ldo_a = reg_wr_en && reg_addr == RVSR_ADDR_LDO_A && loaded_reg;
	assign wr_ldo_b = reg_wr_en && reg_addr == RVSR_ADDR_LDO_B && loaded_reg;
	assign wr_ldo = wr_ldo_a || wr_ldo_b;
	assign strap_preset = RVSR_STRAP_DEFAULT[pin_clean[1:0]];

	always_comb begin
		conv_low_next = conv_low_reg;
		conv_high_next = conv_high_reg;
		slew_next = slew_reg;
		ldo_next = ldo_reg;
		settle_next = settle_reg;
		loaded_next = loaded_reg;
		if (wr_conv_low) begin
			conv_low_next = reg_wr_data[5:0];
		end
		if (wr_conv_high) begin
			conv_high_next = reg_wr_data[5:0];
		end
		if (wr_slew) begin
			slew_next = reg_wr_data[2:0];
		end
		// one-shot preset once the filtered strap levels are valid
		if (!loaded_reg) begin
			if (settle_reg == RVSR_STRAP_SETTLE) begin
				ldo_next = strap_preset;
				loaded_next = 1'b1;
			end else begin
				settle_next = settle_reg + 3'h1;
			end
		end
		if (wr_ldo_a) begin
			ldo_next[1] = reg_wr_data[RVSR_LDO_UPPER_LSB +: 3];
			ldo_next[0] = reg_wr_data[RVSR_LDO_LOWER_LSB +: 3];
		end
		if (wr_ldo_b) begin
			ldo_next[3] = reg_wr_data[RVSR_LDO_UPPER_LSB +: 3];
			ldo_next[2] = reg_wr_data[RVSR_LDO_LOWER_LSB +: 3];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			conv_low_reg <= RVSR_CONV_LOW_RST;
			conv_high_reg <= RVSR_CONV_HIGH_RST;
			slew_reg <= RVSR_SLEW_RST;
			ldo_reg <= '0;
			settle_reg <= 3'h0;
			loaded_reg <= 1'b0;
		end else begin
			conv_low_reg <= conv_low_next;
			conv_high_reg <= conv_high_next;
			slew_reg <= slew_next;
			ldo_reg <= ldo_next;
			settle_reg <= settle_next;
			loaded_reg <= loaded_next;
		end
	end

	// registered read port; unmapped addresses and reserved bits read zero
	always_comb begin
		rd_next = rd_reg;
		if (reg_rd_en) begin
			case (reg_addr)
				RVSR_ADDR_CONV_LOW: rd_next = {2'h0, conv_low_reg};
				RVSR_ADDR_CONV_HIGH: rd_next = {2'h0, conv_high_reg};
				RVSR_ADDR_SLEW: rd_next = {5'h00, slew_reg};
				RVSR_ADDR_LDO_A: rd_next = {1'b0, ldo_reg[1], 1'b0, ldo_reg[0]};
				RVSR_ADDR_LDO_B: rd_next = {1'b0, ldo_reg[3], 1'b0, ldo_reg[2]};
				default: rd_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			rd_reg <= 8'h00;
		end else begin
			rd_reg <= rd_next;
		end
	end

	// converter two ramp
	rvsr_ramp_if rif ();

	assign rif.target_code = pin_clean[2] ? conv_high_reg : conv_low_reg;
	assign rif.slew_code = slew_reg;

	rvsr_ramp #(
		.STEP_BASE_CYCLES(STEP_BASE_CYCLES)
	) u_ramp (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.rif(rif)
	);

	// voltage decode of applied codes
	rvsr_mv_t conv_mv_reg, conv_mv_next;

	always_comb begin
		conv_mv_next = rvsr_conv_mv(rif.applied_code);
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			conv_mv_reg <= 12'h000;
		end else begin
			conv_mv_reg <= conv_mv_next;
		end
	end

	genvar gl;
	generate
		for (gl = 0; gl < 4; gl++) begin : g_ldo_mv
			rvsr_mv_t mv_reg, mv_next;
			always_comb begin
				mv_next = rvsr_ldo_mv(2'(gl), ldo_reg[gl]);
			end
			always_ff @(posedge ref_clk) begin
				if (!rstn) begin
					mv_reg <= 12'h000;
				end else begin
					mv_reg <= mv_next;
				end
			end
			assign linear_reg_mv[gl] = mv_reg;
		end
	endgenerate

	assign reg_rd_data = rd_reg;
	assign slew_code = slew_reg;
	assign linear_reg_code = ldo_reg;
	assign converter_code = rif.applied_code;
	assign converter_mv = conv_mv_reg;
	assign ramp_busy = rif.busy;
	assign presets_loaded = loaded_reg;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	a_slew_reset_value: assert property ($rose(rstn) |-> slew_reg == 3'h6)
		else $error("slew code not 110 after lockout");

	a_slew_reserved_read: assert property ((reg_rd_en && reg_addr == RVSR_ADDR_SLEW)
		|=> reg_rd_data[7:3] == 5'h00 && reg_rd_data[2:0] == $past(slew_reg))
		else $error("slew readback wrong or reserved bits set");

	a_ldo_reserved_read: assert property ((reg_rd_en && reg_addr == RVSR_ADDR_LDO_B)
		|=> reg_rd_data[7] == 1'b0 && reg_rd_data[3] == 1'b0 && reg_rd_data[6:4] == $past(ldo_reg[3]))
		else $error("regulator register readback wrong");

	a_strap_preset_load: assert property ($rose(loaded_reg)
		|-> ldo_reg == RVSR_STRAP_DEFAULT[$past(pin_clean[1:0])])
		else $error("regulator codes not preset from straps");

	a_strap_hold_codes: assert property ((loaded_reg && $past(loaded_reg) && !$past(wr_ldo))
		|-> $stable(ldo_reg))
		else $error("regulator codes changed without a write");

	a_host_override: assert property (wr_ldo_a
		|=> ldo_reg[1] == $past(reg_wr_data[6:4]) && ldo_reg[0] == $past(reg_wr_data[2:0]))
		else $error("host write did not replace regulator codes");

	a_conv_decode_top: assert property ((converter_code == 6'h3f) |=> converter_mv == 12'hce4)
		else $error("code 111111 did not decode to 3.3 V");

	a_ldo_two_decode: assert property ((linear_reg_code[1] == 3'h6) |=> linear_reg_mv[1] == 12'hb54)
		else $error("regulator two code 110 not 2.9 V");

	a_ldo_four_decode: assert property ((linear_reg_code[3] == 3'h0) |=> linear_reg_mv[3] == 12'h3e8)
		else $error("regulator four code 000 not 1.0 V");

	a_ldo_one_decode: assert property ((linear_reg_code[0] == 3'h7) |=> linear_reg_mv[0] == 12'haf0)
		else $error("regulator one code 111 not 2.8 V");

	sequence s_lockout_release;
		$rose(rstn);
	endsequence

	sequence s_preset_wait;
		(!loaded_reg && ldo_reg == '0) [*5];
	endsequence

	// presets land on the fifth edge after release, never earlier
	a_preset_timing: assert property (s_lockout_release |-> s_preset_wait ##1 loaded_reg)
		else $error("strap preset not loaded on the fifth edge after release");

	// a select level held five edges has passed the three-flop filter
	sequence s_select_high_held;
		step_down_two_select_pin [*5];
	endsequence

	sequence s_select_low_held;
		(!step_down_two_select_pin) [*5];
	endsequence

	a_select_high_target: assert property (s_select_high_held |-> rif.target_code == conv_high_reg)
		else $error("select pin high did not pick the high target");

	a_select_low_target: assert property (s_select_low_held |-> rif.target_code == conv_low_reg)
		else $error("select pin low did not pick the low target");

	sequence s_slew_write_gap;
		wr_slew ##1 !wr_slew;
	endsequence

	// a read two cycles after a write returns what was written
	a_slew_write_read: assert property ((s_slew_write_gap ##1 (reg_rd_en && reg_addr == RVSR_ADDR_SLEW))
		|=> reg_rd_data == {5'h00, $past(reg_wr_data[2:0], 3)})
		else $error("slew write not returned by the next read");

	a_conv_low_read: assert property ((reg_rd_en && reg_addr == RVSR_ADDR_CONV_LOW)
		|=> reg_rd_data == {2'h0, $past(conv_low_reg)})
		else $error("converter low target readback wrong");

endmodule : rvsr_top

// file: design/rvsr_pkg.sv
// constants, types and decode functions for the regulator voltage select registers
package rvsr_pkg;

	typedef logic [11:0] rvsr_mv_t;

	// register byte addresses on the host register port
	localparam logic [7:0] RVSR_ADDR_CONV_LOW = 8'h05;
	localparam logic [7:0] RVSR_ADDR_CONV_HIGH = 8'h06;
	localparam logic [7:0] RVSR_ADDR_SLEW = 8'h07;
	localparam logic [7:0] RVSR_ADDR_LDO_A = 8'h08;
	localparam logic [7:0] RVSR_ADDR_LDO_B = 8'h09;

	// values after undervoltage lockout, and the slew code that applies the target at once
	localparam logic [5:0] RVSR_CONV_LOW_RST = 6'h10;
	localparam logic [5:0] RVSR_CONV_HIGH_RST = 6'h08;
	localparam logic [2:0] RVSR_SLEW_RST = 3'h6;
	localparam logic [2:0] RVSR_SLEW_IMMEDIATE = 3'h7;

	// field positions inside the linear regulator control registers
	localparam int RVSR_LDO_UPPER_LSB = 4;
	localparam int RVSR_LDO_LOWER_LSB = 0;

	// strap sampling: cycles after release until the filtered strap level is valid
	localparam logic [2:0] RVSR_STRAP_SETTLE = 3'h4;

	// preset codes per strap combination, packed {four, three, two, one}
	localparam logic [11:0] RVSR_STRAP_DEFAULT [4] = '{12'he39, 12'h6d4, 12'h2c2, 12'hfff};

	// ramp timing: one code step of 25 mV at the fastest rate of 7.2 mV/us
	localparam int RVSR_CLK_PERIOD_NS = 50;
	localparam int RVSR_STEP_UV = 25000;
	localparam int RVSR_FAST_RATE_UV_PER_US = 7200;
	localparam int RVSR_FAST_STEP_NS = RVSR_STEP_UV * 1000 / RVSR_FAST_RATE_UV_PER_US;
	localparam int RVSR_FAST_STEP_CYCLES = RVSR_FAST_STEP_NS / RVSR_CLK_PERIOD_NS;

	localparam rvsr_mv_t RVSR_LDO_ONE_MV [8] = '{12'h320, 12'h3e8, 12'h4b0, 12'h5dc,
		12'h708, 12'h834, 12'h9c4, 12'haf0};
	localparam rvsr_mv_t RVSR_LDO_TWO_MV [8] = '{12'h4b0, 12'h514, 12'h708, 12'ha28,
		12'ha8c, 12'haf0, 12'hb54, 12'hbb8};
	localparam rvsr_mv_t RVSR_LDO_FOUR_MV [8] = '{12'h3e8, 12'h4b0, 12'h514, 12'h708,
		12'ha28, 12'ha8c, 12'haf0, 12'hbb8};

	function automatic rvsr_mv_t rvsr_conv_mv(input logic [5:0] code);
		rvsr_mv_t k;
		k = {7'h00, code[4:0]};
		if (!code[5]) begin
			return 12'h320 + k * 12'h019;
		end else if (code[4:0] <= 5'h1c) begin
			return 12'h640 + k * 12'h032;
		end else begin
			return 12'hc1c + (k - 12'h01d) * 12'h064;
		end
	endfunction : rvsr_conv_mv

	// idx 0..3 selects regulator one..four
	function automatic rvsr_mv_t rvsr_ldo_mv(input logic [1:0] idx, input logic [2:0] code);
		case (idx)
			2'h0, 2'h2: return RVSR_LDO_ONE_MV[code];
			2'h1: return RVSR_LDO_TWO_MV[code];
			default: return RVSR_LDO_FOUR_MV[code];
		endcase
	endfunction : rvsr_ldo_mv

endpackage : rvsr_pkg

// file: design/rvsr_ramp_if.sv
// carrier between the register bank and the converter ramp stepper
`timescale 1ns/100ps
interface rvsr_ramp_if;
	logic [5:0] target_code;
	logic [2:0] slew_code;
	logic [5:0] applied_code;
	logic busy;

	modport ctrl (output target_code, output slew_code, input applied_code, input busy);
	modport ramp (input target_code, input slew_code, output applied_code, output busy);
endinterface : rvsr_ramp_if

// file: design/rvsr_ramp.sv
// converter two code stepper: walks the applied code toward the target at the slew rate
`timescale 1ns/100ps
module rvsr_ramp #(
	parameter int STEP_BASE_CYCLES = rvsr_pkg::RVSR_FAST_STEP_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rstn,
	rvsr_ramp_if.ramp rif
);
	import rvsr_pkg::*;

	logic [15:0] cnt_reg, cnt_next;
	logic [5:0] applied_reg, applied_next;
	logic busy_reg, busy_next;
	logic [15:0] interval;
	logic [5:0] stepped;

	always_comb begin
		// each slower code roughly halves the rate, so the interval doubles
		interval = 16'(STEP_BASE_CYCLES) << (3'h6 - rif.slew_code);
		stepped = (rif.target_code > applied_reg) ? applied_reg + 6'h01 : applied_reg - 6'h01;
		cnt_next = 16'h0000;
		applied_next = applied_reg;
		busy_next = 1'b0;
		if (applied_reg != rif.target_code) begin
			if (rif.slew_code == RVSR_SLEW_IMMEDIATE) begin
				applied_next = rif.target_code;
			end else begin
				busy_next = 1'b1;
				if (cnt_reg >= interval - 16'h0001) begin
					applied_next = stepped;
					busy_next = (stepped != rif.target_code);
				end else begin
					cnt_next = cnt_reg + 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			cnt_reg <= 16'h0000;
			applied_reg <= RVSR_CONV_LOW_RST;
			busy_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			applied_reg <= applied_next;
			busy_reg <= busy_next;
		end
	end

	assign rif.applied_code = applied_reg;
	assign rif.busy = busy_reg;

	a_ramp_immediate_apply: assert property (@(posedge ref_clk) disable iff (!rstn)
		(applied_reg != rif.target_code && rif.slew_code == RVSR_SLEW_IMMEDIATE)
		|=> applied_reg == $past(rif.target_code))
		else $error("immediate slew did not apply target in one cycle");

	// busy falls on the edge that lands the last step, not one later
	a_ramp_busy_set: assert property (@(posedge ref_clk) disable iff (!rstn)
		(applied_reg != rif.target_code && rif.slew_code != RVSR_SLEW_IMMEDIATE)
		|=> busy_reg == (applied_reg != $past(rif.target_code)))
		else $error("busy flag does not track the distance to the target");

	a_ramp_single_step: assert property (@(posedge ref_clk) disable iff (!rstn)
		($changed(applied_reg) && $past(rif.slew_code) != RVSR_SLEW_IMMEDIATE)
		|-> (applied_reg == 6'($past(applied_reg) + 6'h01) || applied_reg == 6'($past(applied_reg) - 6'h01)))
		else $error("ramp moved by more than one code");

endmodule : rvsr_ramp

// file: verif/rvsr_host_model.sv
// host side of the register port: strobe writes and reads from the serial engine
`timescale 1ns/100ps
module rvsr_host_model (
	input wire logic ref_clk,
	output logic reg_wr_en,
	output logic reg_rd_en,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wr_data,
	input wire logic [7:0] reg_rd_data
);
	initial begin
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = 8'hff;
		reg_wr_data = 8'hff;
	end

	// one-cycle strobe; address and data show the inverse once released
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_wr_en = 1'b1;
		reg_addr = a;
		reg_wr_data = d;
		@(negedge ref_clk);
		reg_wr_en = 1'b0;
		reg_addr = ~a;
		reg_wr_data = ~d;
	endtask : wr

	// read data is registered on the strobe edge and taken at the following falling edge
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		@(negedge ref_clk);
		reg_rd_en = 1'b1;
		reg_addr = a;
		@(negedge ref_clk);
		q = reg_rd_data;
		reg_rd_en = 1'b0;
		reg_addr = ~a;
	endtask : rd
endmodule : rvsr_host_model

// file: verif/testbench.sv
// self-checking bench for the regulator voltage select registers
`timescale 1ns/100ps
module testbench;
	import rvsr_pkg::*;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] q;} rvsr_row_t;
	localparam rvsr_row_t ROWS [8] = '{'{8'h07, 8'hff, 8'h07}, '{8'h07, 8'h00, 8'h00}, '{8'h08, 8'hff, 8'h77},
		'{8'h08, 8'h5a, 8'h52}, '{8'h09, 8'hff, 8'h77}, '{8'h05, 8'hff, 8'h3f}, '{8'h06, 8'h21, 8'h21},
		'{8'h0a, 8'hff, 8'h00}};
	localparam rvsr_mv_t MV_ONE [8] = '{12'h320, 12'h3e8, 12'h4b0, 12'h5dc, 12'h708, 12'h834, 12'h9c4, 12'haf0};
	localparam rvsr_mv_t MV_TWO [8] = '{12'h4b0, 12'h514, 12'h708, 12'ha28, 12'ha8c, 12'haf0, 12'hb54, 12'hbb8};
	localparam rvsr_mv_t MV_FOUR [8] = '{12'h3e8, 12'h4b0, 12'h514, 12'h708, 12'ha28, 12'ha8c, 12'haf0, 12'hbb8};
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic strap_select_a = 1'b0;
	logic strap_select_b = 1'b0;
	logic sel = 1'b0;
	logic reg_wr_en, reg_rd_en, ramp_busy, presets_loaded;
	logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
	logic [2:0] slew_code;
	logic [3:0][2:0] linear_reg_code;
	logic [3:0][11:0] linear_reg_mv;
	logic [5:0] converter_code;
	rvsr_mv_t converter_mv;
	int mismatches = 0;
	int cmp_count = 0;

	rvsr_host_model u_host (.ref_clk(ref_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
		.reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data));
	rvsr_top #(.STEP_BASE_CYCLES(2)) u_dut (.ref_clk(ref_clk), .rstn(rstn), .strap_select_a(strap_select_a),
		.strap_select_b(strap_select_b), .step_down_two_select_pin(sel), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
		.slew_code(slew_code), .linear_reg_code(linear_reg_code), .linear_reg_mv(linear_reg_mv),
		.converter_code(converter_code), .converter_mv(converter_mv), .ramp_busy(ramp_busy),
		.presets_loaded(presets_loaded));

	initial begin
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic rd_check(input logic [7:0] a, input logic [7:0] exp, input string what);
		logic [7:0] q;
		u_host.rd(a, q);
		check({8'h00, q}, {8'h00, exp}, what);
	endtask : rd_check

	task automatic do_reset(input logic [1:0] idx);
		@(negedge ref_clk);
		rstn = 1'b0;
		{strap_select_b, strap_select_a} = idx;
		repeat (8) @(negedge ref_clk);
		rstn = 1'b1;
	endtask : do_reset

	task automatic wait_loaded();
		for (int i = 0; i < 20 && presets_loaded !== 1'b1; i++) @(negedge ref_clk);
	endtask : wait_loaded

	initial begin
		#3000000;
		mismatches++;
		$display("[FAIL] %0t watchdog expired", $time);
		tally_and_finish();
	end

	initial begin
		logic [11:0] p;
		logic [15:0] e;
		logic [5:0] t;
		int n;
		for (int idx = 0; idx < 4; idx++) begin
			do_reset(idx[1:0]);
			// early write must lose against the preset
			u_host.wr(8'h08, 8'h00);
			wait_loaded();
			check({15'h0, presets_loaded}, 16'h0001, "presets loaded");
			{strap_select_b, strap_select_a} = ~idx[1:0];
			repeat (4) @(negedge ref_clk);
			p = RVSR_STRAP_DEFAULT[idx];
			check({4'h0, linear_reg_code}, {4'h0, p}, "preset codes");
			rd_check(8'h08, {1'b0, p[5:3], 1'b0, p[2:0]}, "preset a");
			rd_check(8'h09, {1'b0, p[11:9], 1'b0, p[8:6]}, "preset b");
			check({4'h0, linear_reg_mv[1]}, {4'h0, MV_TWO[p[5:3]]}, "preset mv");
			rd_check(8'h07, 8'h06, "slew reset");
		end
		$display("strap preset test done");
		foreach (ROWS[i]) begin
			u_host.wr(ROWS[i].a, ROWS[i].d);
			rd_check(ROWS[i].a, ROWS[i].q, "row readback");
		end
		$display("register row test done");
		for (int c = 0; c < 8; c++) begin
			u_host.wr(8'h08, {1'b0, c[2:0], 1'b0, c[2:0]});
			u_host.wr(8'h09, {1'b0, c[2:0], 1'b0, c[2:0]});
			repeat (2) @(negedge ref_clk);
			check({4'h0, linear_reg_mv[0]}, {4'h0, MV_ONE[c]}, "reg one mv");
			check({4'h0, linear_reg_mv[1]}, {4'h0, MV_TWO[c]}, "reg two mv");
			check({4'h0, linear_reg_mv[2]}, {4'h0, MV_ONE[c]}, "reg three mv");
			check({4'h0, linear_reg_mv[3]}, {4'h0, MV_FOUR[c]}, "reg four mv");
		end
		$display("regulator decode test done");
		u_host.wr(8'h07, 8'h07);
		for (int c = 32; c < 64; c++) begin
			u_host.wr(8'h05, c[7:0]);
			repeat (3) @(negedge ref_clk);
			e = 16'((c <= 60) ? 1600 + 50 * (c - 32) : 3000 + 100 * (c - 60));
			check({10'h000, converter_code}, c[15:0], "immediate code");
			check({4'h0, converter_mv}, e, "converter mv");
		end
		$display("converter decode test done");
		u_host.wr(8'h06, 8'h21);
		sel = 1'b1;
		repeat (8) @(negedge ref_clk);
		check({10'h000, converter_code}, 16'h0021, "high target");
		sel = 1'b0;
		repeat (8) @(negedge ref_clk);
		check({10'h000, converter_code}, 16'h003f, "low target");
		$display("select pin test done");
		for (int s = 0; s < 7; s++) begin
			u_host.wr(8'h07, s[7:0]);
			t = (converter_code === 6'h3f) ? 6'h3b : 6'h3f;
			u_host.wr(8'h05, {2'b00, t});
			n = 0;
			for (int k = 0; k < 1000 && (n == 0 || ramp_busy === 1'b1); k++) begin
				@(negedge ref_clk);
				if (ramp_busy === 1'b1) n++;
			end
			e = 16'(4 * (2 << (6 - s)));
			check(16'(n), e - 16'h0001, "ramp duration");
			check({10'h000, converter_code}, {10'h000, t}, "ramp end code");
		end
		$display("ramp test done");
		u_host.wr(8'h07, 8'h03);
		repeat (20) @(negedge ref_clk);
		check({13'h0, slew_code}, 16'h0003, "slew field");
		rd_check(8'h07, 8'h03, "slew kept");
		do_reset(2'h0);
		wait_loaded();
		rd_check(8'h07, 8'h06, "slew after lockout");
		check({13'h0, slew_code}, 16'h0006, "slew code after lockout");
		p = RVSR_STRAP_DEFAULT[0];
		rd_check(8'h08, {1'b0, p[5:3], 1'b0, p[2:0]}, "codes after lockout");
		$display("lockout test done");
		tally_and_finish();
	end
endmodule : testbench
